/* File: bopx_map.svh */
// constants for the byte-op execute unit: widths, opcodes, reset values
`ifndef BOPX_MAP_SVH
`define BOPX_MAP_SVH
`define BOPX_DATA_W 8
`define BOPX_ADDR_W 7
`define BOPX_PC_W 13
`define BOPX_SP_W 3
`define BOPX_DEPTH 8
`define BOPX_OP_W 4
`define BOPX_OP_NOP 4'h0
`define BOPX_OP_OR 4'h1
`define BOPX_OP_STORE 4'h2
`define BOPX_OP_COPY 4'h3
`define BOPX_OP_ROL 4'h4
`define BOPX_OP_ROR 4'h5
`define BOPX_OP_RETURN_LITERAL_OP 4'h6
`define BOPX_OP_RETURN_INTERRUPT_OP 4'h7
`define BOPX_DEST_ACC 1'h0
`define BOPX_DEST_FILE 1'h1
`define BOPX_ACC_RST 8'h00
`define BOPX_PC_RST 13'h0000
`define BOPX_PC_STEP 13'h0001
`define BOPX_SP_RST 3'h0
`define BOPX_SP_STEP 3'h1
`define BOPX_BYTE_ZERO 8'h00
`define BOPX_MSB 7
`define BOPX_LSB 0
`endif

/* File: bopx_pkg.sv */
// types for the byte-op execute unit
package bopx_pkg;
`include "bopx_map.svh"
  typedef enum logic [`BOPX_OP_W-1:0] {
    BOPX_NOP = `BOPX_OP_NOP,
    BOPX_OR = `BOPX_OP_OR,
    BOPX_STORE = `BOPX_OP_STORE,
    BOPX_COPY = `BOPX_OP_COPY,
    BOPX_ROL = `BOPX_OP_ROL,
    BOPX_ROR = `BOPX_OP_ROR,
    BOPX_RETURN_LITERAL_OP = `BOPX_OP_RETURN_LITERAL_OP,
    BOPX_RETURN_INTERRUPT_OP = `BOPX_OP_RETURN_INTERRUPT_OP
  } bopx_op_t;
  typedef enum logic [1:0] {
    BOPX_S_RUN = 2'h0,
    BOPX_S_FLUSH = 2'h1
  } bopx_state_t;
endpackage

/* File: bopx_stack.sv */
// eight-level hardware return stack, flip-flop storage, wraps on overflow
`timescale 1ns/1ps
`include "bopx_map.svh"
module bopx_stack
  import bopx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_push,
  input wire logic [`BOPX_PC_W-1:0] i_push_addr,
  input wire logic i_pop,
  output logic [`BOPX_PC_W-1:0] o_head
);
  logic [`BOPX_PC_W-1:0] mem_ff [`BOPX_DEPTH];
  logic [`BOPX_SP_W-1:0] sp_ff;
  wire [`BOPX_SP_W-1:0] head_idx = sp_ff - `BOPX_SP_STEP;

  assign o_head = mem_ff[head_idx];

  // pop wins over a push in the same cycle; the core can issue both, and the push is then dropped
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sp_ff <= `BOPX_SP_RST;
    end else if (i_ce && i_pop) begin
      sp_ff <= head_idx;
    end else if (i_ce && i_push) begin
      sp_ff <= sp_ff + `BOPX_SP_STEP;
    end
  end

  // contents need no reset: an empty pop returns stale data, as in silicon
  always_ff @(posedge i_clk) begin
    if (i_ce && i_push && !i_pop) begin
      mem_ff[sp_ff] <= i_push_addr;
    end
  end
endmodule

/* File: bopx_exec.sv */
// byte-op execute unit: or, store, copy, rotates, nop, returns
//
// What this block does
// - OR accumulator with register into accumulator or register; sets zero.
// - store copies accumulator to register at 7-bit address, no flags.
// - copy moves register to accumulator (d=0) or back into itself (d=1).
// - copy sets zero from the moved value, testing a register in place.
// - rotate left through carry; old carry to bit 0, bit 7 to carry.
// - rotate right through carry; old carry to bit 7, bit 0 to carry.
// - return-literal loads accumulator with 8-bit literal; flags unchanged.
// - return-literal pops the return stack into the program counter.
// - return-literal and return-interrupt take two instruction cycles, others take one.
`timescale 1ns/1ps
`include "bopx_map.svh"
module bopx_exec
  import bopx_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_OP_VALID,
  input wire logic [`BOPX_OP_W-1:0] I_OP_CODE,
  input wire logic [`BOPX_ADDR_W-1:0] I_FILE_ADDR,
  input wire logic I_DEST_SEL,
  input wire logic [`BOPX_DATA_W-1:0] I_LITERAL,
  input wire logic [`BOPX_DATA_W-1:0] I_FILE_RDATA,
  input wire logic I_PUSH_VALID,
  input wire logic [`BOPX_PC_W-1:0] I_PUSH_ADDR,
  output logic O_BUSY,
  output logic O_DONE,
  output logic [`BOPX_DATA_W-1:0] O_ACC,
  output logic O_ZERO,
  output logic O_CARRY,
  output logic O_GLOBAL_IRQ_ALLOW,
  output logic [`BOPX_PC_W-1:0] O_PC,
  output logic O_FILE_WE,
  output logic [`BOPX_ADDR_W-1:0] O_FILE_WADDR,
  output logic [`BOPX_DATA_W-1:0] O_FILE_WDATA
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_zero(input logic [`BOPX_DATA_W-1:0] v);
    is_zero = (v == `BOPX_BYTE_ZERO);
  endfunction

  // returns {new carry, rotated byte}
  function automatic logic [`BOPX_DATA_W:0] rotate(
    input logic [`BOPX_DATA_W-1:0] v,
    input logic c,
    input logic left
  );
    if (left) begin
      rotate = {v[`BOPX_MSB], v[`BOPX_MSB-1:`BOPX_LSB], c};
    end else begin
      rotate = {v[`BOPX_LSB], c, v[`BOPX_MSB:`BOPX_LSB+1]};
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bopx_state_t state_ff;
  bopx_state_t nxt_state;
  logic [`BOPX_DATA_W-1:0] acc_ff;
  logic zero_ff;
  logic carry_ff;
  logic gie_ff;
  logic [`BOPX_PC_W-1:0] pc_ff;
  logic busy_ff;
  logic done_ff;
  logic we_ff;
  logic [`BOPX_ADDR_W-1:0] waddr_ff;
  logic [`BOPX_DATA_W-1:0] wdata_ff;
  logic [`BOPX_PC_W-1:0] stack_head;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire bopx_op_t op = bopx_op_t'(I_OP_CODE);
  wire op_known = (I_OP_CODE <= `BOPX_OP_RETURN_INTERRUPT_OP);
  // requests are refused while a two-cycle return drains
  wire take = I_CE && I_OP_VALID && op_known && (state_ff == BOPX_S_RUN);
  wire is_rot = (op == BOPX_ROL) || (op == BOPX_ROR);
  wire is_ret = (op == BOPX_RETURN_LITERAL_OP) || (op == BOPX_RETURN_INTERRUPT_OP);
  wire has_dest = (op == BOPX_OR) || (op == BOPX_COPY) || is_rot;
  wire to_file = has_dest && (I_DEST_SEL == `BOPX_DEST_FILE);

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  wire [`BOPX_DATA_W-1:0] or_res = acc_ff | I_FILE_RDATA;
  wire [`BOPX_DATA_W:0] rot_res =
    rotate(I_FILE_RDATA, carry_ff, op == BOPX_ROL);
  wire [`BOPX_DATA_W-1:0] alu_res =
    (op == BOPX_OR) ? or_res :
    is_rot ? rot_res[`BOPX_DATA_W-1:0] :
    I_FILE_RDATA;

  wire wr_file = take && ((op == BOPX_STORE) || to_file);
  wire wr_acc = take && ((has_dest && !to_file) || (op == BOPX_RETURN_LITERAL_OP));
  wire [`BOPX_DATA_W-1:0] nxt_acc =
    (op == BOPX_RETURN_LITERAL_OP) ? I_LITERAL : alu_res;
  wire [`BOPX_DATA_W-1:0] nxt_wdata =
    (op == BOPX_STORE) ? acc_ff : alu_res;
  // store, return_literal_op, return_interrupt_op and nop leave both flags alone
  wire upd_zero = take && ((op == BOPX_OR) || (op == BOPX_COPY));
  wire upd_carry = take && is_rot;
  wire nxt_zero = is_zero(alu_res);
  wire nxt_carry = rot_res[`BOPX_DATA_W];
  wire [`BOPX_PC_W-1:0] nxt_pc =
    is_ret ? stack_head : pc_ff + `BOPX_PC_STEP;
  assign nxt_state = (take && is_ret) ? BOPX_S_FLUSH : BOPX_S_RUN;

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  bopx_stack u_stack (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_push(I_PUSH_VALID),
    .i_push_addr(I_PUSH_ADDR),
    .i_pop(take && is_ret),
    .o_head(stack_head)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_ff <= BOPX_S_RUN;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (I_CE) begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state == BOPX_S_FLUSH);
      // done marks the last cycle of every instruction
      done_ff <= (take && !is_ret) || (state_ff == BOPX_S_FLUSH);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      acc_ff <= `BOPX_ACC_RST;
      pc_ff <= `BOPX_PC_RST;
    end else if (I_CE) begin
      if (wr_acc) begin
        acc_ff <= nxt_acc;
      end
      if (take) begin
        pc_ff <= nxt_pc;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      zero_ff <= 1'b0;
      carry_ff <= 1'b0;
      gie_ff <= 1'b0;
    end else if (I_CE) begin
      if (upd_zero) begin
        zero_ff <= nxt_zero;
      end
      if (upd_carry) begin
        carry_ff <= nxt_carry;
      end
      if (take && (op == BOPX_RETURN_INTERRUPT_OP)) begin
        gie_ff <= 1'b1;
      end
    end
  end

  // write port is a one-cycle strobe; frozen only while clock enable is low
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      we_ff <= 1'b0;
      waddr_ff <= {`BOPX_ADDR_W{1'b0}};
      wdata_ff <= `BOPX_BYTE_ZERO;
    end else if (I_CE) begin
      we_ff <= wr_file;
      if (wr_file) begin
        waddr_ff <= I_FILE_ADDR;
        wdata_ff <= nxt_wdata;
      end
    end
  end

  assign O_BUSY = busy_ff;
  assign O_DONE = done_ff;
  assign O_ACC = acc_ff;
  assign O_ZERO = zero_ff;
  assign O_CARRY = carry_ff;
  assign O_GLOBAL_IRQ_ALLOW = gie_ff;
  assign O_PC = pc_ff;
  assign O_FILE_WE = we_ff;
  assign O_FILE_WADDR = waddr_ff;
  assign O_FILE_WDATA = wdata_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_or_result: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_OR |=>
      O_ZERO == ($past(acc_ff | I_FILE_RDATA) == `BOPX_BYTE_ZERO)
      && (O_FILE_WE ? O_FILE_WDATA : O_ACC)
        == ($past(acc_ff) | $past(I_FILE_RDATA)))
    else $error("or result or zero flag wrong");
  chk_store_copy: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_STORE |=> O_FILE_WE && O_FILE_WDATA == $past(O_ACC)
      && O_FILE_WADDR == $past(I_FILE_ADDR) && $stable(O_ZERO)
      && $stable(O_CARRY))
    else $error("store wrote wrong data or touched flags");
  chk_copy_dest: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_COPY && !I_DEST_SEL |=>
      O_ACC == $past(I_FILE_RDATA) && !O_FILE_WE)
    else $error("copy to accumulator wrong");
  chk_copy_zero: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_COPY |=>
      O_ZERO == ($past(I_FILE_RDATA) == `BOPX_BYTE_ZERO))
    else $error("copy zero flag wrong");
  chk_rol_carry: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_ROL |=> O_CARRY == $past(I_FILE_RDATA[`BOPX_MSB])
      && (O_FILE_WE ? O_FILE_WDATA : O_ACC)
        == {$past(I_FILE_RDATA[`BOPX_MSB-1:`BOPX_LSB]), $past(O_CARRY)})
    else $error("rotate left wrong");
  chk_ror_carry: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_ROR |=> O_CARRY == $past(I_FILE_RDATA[`BOPX_LSB])
      && (O_FILE_WE ? O_FILE_WDATA : O_ACC)
        == {$past(O_CARRY), $past(I_FILE_RDATA[`BOPX_MSB:`BOPX_LSB+1])})
    else $error("rotate right wrong");
  chk_return_literal_op_load: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_RETURN_LITERAL_OP |=> O_ACC == $past(I_LITERAL)
      && $stable(O_ZERO) && $stable(O_CARRY) && !O_FILE_WE)
    else $error("return literal load wrong");
  chk_ret_pc: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && is_ret |=> O_PC == $past(stack_head))
    else $error("return did not load stack head");
  chk_return_literal_op_cycles: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && is_ret |=> O_BUSY && !O_DONE
      ##1 (!$past(I_CE) || (!O_BUSY && O_DONE)))
    else $error("return did not take two cycles");
  chk_return_interrupt_op_gie: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_RETURN_INTERRUPT_OP |=> O_GLOBAL_IRQ_ALLOW && $stable(O_ZERO)
      && $stable(O_CARRY) && $stable(O_ACC))
    else $error("return from interrupt wrong");
  chk_nop_quiet: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    take && op == BOPX_NOP |=> !O_FILE_WE && $stable(O_ACC)
      && $stable(O_ZERO) && $stable(O_CARRY) && O_DONE
      && O_PC == $past(O_PC) + `BOPX_PC_STEP)
    else $error("nop changed state");
endmodule

/* File: bopx_fmem.sv */
// register-memory partner model for the byte-op execute unit
`timescale 1ns/1ps
`include "bopx_map.svh"
module bopx_fmem (
  input wire logic i_clk,
  input wire logic [`BOPX_ADDR_W-1:0] i_raddr,
  output logic [`BOPX_DATA_W-1:0] o_rdata,
  input wire logic i_we,
  input wire logic [`BOPX_ADDR_W-1:0] i_waddr,
  input wire logic [`BOPX_DATA_W-1:0] i_wdata
);
  logic [`BOPX_DATA_W-1:0] mem [0:127];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // forward the pending write: the next op is taken on the same edge
  assign o_rdata = (i_we && i_waddr == i_raddr) ? i_wdata : mem[i_raddr];
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
endmodule

/* File: tb_byte_op_execute_unit.sv */
// self-checking bench for the byte-op execute unit
`timescale 1ns/1ps
module tb_byte_op_execute_unit;
  import bopx_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [6:0] file_addr = 7'h00;
  logic dest_sel = 1'b0;
  logic [7:0] literal = 8'h00;
  logic push_valid = 1'b0;
  logic [12:0] push_addr = 13'h0000;
  logic [7:0] file_rdata, acc, file_wdata;
  logic busy, done, zero, carry, global_irq_allow, file_we;
  logic [12:0] pc;
  logic [6:0] file_waddr;
  int m_acc, m_z, m_c, m_gie, m_pc, sp, depth;
  int m_mem [128];
  int stk [8];
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rng = 32'h6837;

  always #50 clk = ~clk;

  bopx_exec bopx_exec_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_OP_VALID(op_valid), .I_OP_CODE(op_code), .I_FILE_ADDR(file_addr),
    .I_DEST_SEL(dest_sel), .I_LITERAL(literal), .I_FILE_RDATA(file_rdata),
    .I_PUSH_VALID(push_valid), .I_PUSH_ADDR(push_addr), .O_BUSY(busy),
    .O_DONE(done), .O_ACC(acc), .O_ZERO(zero), .O_CARRY(carry),
    .O_GLOBAL_IRQ_ALLOW(global_irq_allow), .O_PC(pc), .O_FILE_WE(file_we),
    .O_FILE_WADDR(file_waddr), .O_FILE_WDATA(file_wdata));
  bopx_fmem bopx_fmem_inst (.i_clk(clk), .i_raddr(file_addr),
    .o_rdata(file_rdata), .i_we(file_we), .i_waddr(file_waddr),
    .i_wdata(file_wdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_state(input int we, input int dn, input int bz);
    check(16'(acc), 16'(m_acc));
    check(16'(zero), 16'(m_z));
    check(16'(carry), 16'(m_c));
    check(16'(global_irq_allow), 16'(m_gie));
    check(16'(pc), 16'(m_pc));
    check(16'(file_we), 16'(we));
    check(16'({done, busy}), 16'({dn[0], bz[0]}));
  endtask

  task automatic idle(input int n);
    op_valid = 1'b0;
    push_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  // holds the push request; the caller releases it through idle or the busy cycle of a return in do_op
  task automatic push(input int p);
    push_valid = 1'b1;
    push_addr = 13'(p);
    @(negedge clk);
    sp = (sp + 1) % 8;
    stk[sp] = p % 8192;
    depth++;
  endtask

  task automatic do_op(input int code, input int a, input int d, input int k);
    int r, res, we, ret;
    op_valid = 1'b1;
    op_code = 4'(code);
    file_addr = 7'(a);
    dest_sel = d[0];
    literal = 8'(k);
    r = m_mem[a];
    we = 0;
    ret = (code == 6 || code == 7);
    case (code)
      1: res = m_acc | r;
      2: res = m_acc;
      3: res = r;
      4: res = ((r << 1) | m_c) & 255;
      5: res = (r >> 1) | (m_c << 7);
      default: res = 0;
    endcase
    if (code == 1 || code == 3) m_z = (res == 0);
    if (code == 4) m_c = r >> 7;
    if (code == 5) m_c = r & 1;
    if (code >= 1 && code <= 5) begin
      if (code == 2 || d == 1) begin
        we = 1;
        m_mem[a] = res;
      end else begin
        m_acc = res;
      end
    end
    if (code == 6) m_acc = k;
    if (code == 7) m_gie = 1;
    if (ret) begin
      m_pc = stk[sp];
      sp = (sp + 7) % 8;
      depth--;
    end else if (code < 8) begin
      m_pc = (m_pc + 1) % 8192;
    end
    @(negedge clk);
    check_state(we, code < 8 && !ret, ret);
    if (we) begin
      check(16'(file_waddr), 16'(a));
      check(16'(file_wdata), 16'(res));
    end
    if (ret) begin
      // a request during the busy cycle must be ignored
      op_code = 4'h1;
      push_valid = 1'b0;
      @(negedge clk);
      check_state(0, 1, 0);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    int unsigned v, w;
    int code;
    for (int i = 0; i < 128; i++) m_mem[i] = (i ^ 'hA5) & 255;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check_state(0, 0, 0);
    // nine pushes wrap the eight-deep ring
    for (int i = 0; i < 9; i++) push(rnd() % 8192);
    // push on the return edge is dropped
    push(13'h1ABC);
    do_op(6, 0, 0, 255);
    do_op(7, 0, 0, 0);
    ce = 1'b0;
    op_valid = 1'b1;
    op_code = 4'h3;
    @(negedge clk);
    // clock enable low freezes the done strobe left by the return
    check_state(0, 1, 0);
    ce = 1'b1;
    idle(1);
    for (int i = 0; i < 300; i++) begin
      v = rnd();
      w = rnd();
      code = v % 10;
      if ((code == 6 || code == 7) && depth <= 0) begin
        idle(1);
        push(w % 8192);
        idle(1);
      end
      do_op(code, (v >> 4) % 128, (v >> 11) & 1, (w >> 16) % 256);
    end
    idle(2);
    finish_test();
  end

  // about thirty-five times the expected run length
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end
endmodule
